// ---- include/msc_cfg.svh ----
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH
// byte addresses in the register page
`define MSC_ALARM_ADDR 10'h214
`define MSC_STATUS_ADDR 10'h215
`define MSC_DELAY_ADDR 10'h216
`define MSC_STAMP_ADDR 10'h219
`define MSC_STAMP_LAST 10'h21e
`define MSC_MSAMP_ADDR 10'h220
`define MSC_DSAMP_ADDR 10'h223
// alarm flag positions
`define MSC_POWER_LOSS_BIT 7
`define MSC_HUMID_OVER_BIT 3
`define MSC_HUMID_UNDER_BIT 2
`define MSC_TEMP_OVER_BIT 1
`define MSC_TEMP_UNDER_BIT 0
// general status positions
`define MSC_AWAIT_BIT 4
`define MSC_WIPED_BIT 3
`define MSC_ACTIVE_BIT 1
// fixed read values of the unused bits
`define MSC_ALARM_FIXED 8'h70
`define MSC_STATUS_FIXED 8'hc0
// reset values
`define MSC_DELAY_RESET 24'h000000
`define MSC_COUNT_RESET 24'h000000
`define MSC_STAMP_RESET 48'h000000000000
// one minute of the rtc seconds tick
`define MSC_SECONDS_PER_MINUTE 6'd60
`endif

// ---- include/msc_pkg.sv ----
package msc_pkg;
  // mission sequencing phases
  typedef enum logic [3:0] {
    MSC_IDLE = 4'b0001,
    MSC_DELAY = 4'b0010,
    MSC_WAIT_TRIG = 4'b0100,
    MSC_RUN = 4'b1000
  } msc_phase_type;
endpackage

// ---- src/msc_sat_cmp.sv ----
`timescale 1ns/10ps
`default_nettype none
// threshold comparison for one quantity, signed 16-bit readings
module msc_sat_cmp (
  input wire logic [15:0] reading,
  input wire logic [15:0] high_limit,
  input wire logic [15:0] low_limit,
  output logic is_high,
  output logic is_low
);
  // both compares are inclusive of the limit
  always_comb begin
    is_high = $signed(reading) >= $signed(high_limit);
    is_low = $signed(reading) <= $signed(low_limit);
  end
endmodule
`default_nettype wire

// ---- src/msc_mission_status.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "msc_cfg.svh"
module msc_mission_status (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic power_on_event,
  input wire logic [9:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_clear,
  input wire logic start_on_trigger,
  input wire logic log_temp_en,
  input wire logic log_humid_en,
  input wire logic temp_high_en,
  input wire logic temp_low_en,
  input wire logic humid_high_en,
  input wire logic humid_low_en,
  input wire logic [15:0] temp_high_limit,
  input wire logic [15:0] temp_low_limit,
  input wire logic [15:0] humid_high_limit,
  input wire logic [15:0] humid_low_limit,
  input wire logic minute_tick,
  input wire logic sample_tick,
  input wire logic conv_done,
  input wire logic conv_forced,
  input wire logic [15:0] temp_reading,
  input wire logic [15:0] humid_reading,
  input wire logic mission_end,
  input wire logic [47:0] rtc_time,
  output logic start_refused,
  output logic sample_commit,
  output logic logging_active_flag
);
  ////////////////////////////////////////////////////////////////////////////
  // comparisons
  logic t_hi, t_lo, h_hi, h_lo;
  msc_sat_cmp temp_cmp (
    .reading(temp_reading),
    .high_limit(temp_high_limit),
    .low_limit(temp_low_limit),
    .is_high(t_hi),
    .is_low(t_lo)
  );
  msc_sat_cmp humid_cmp (
    .reading(humid_reading),
    .high_limit(humid_high_limit),
    .low_limit(humid_low_limit),
    .is_high(h_hi),
    .is_low(h_lo)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state
  msc_pkg::msc_phase_type phase, next_phase;
  logic [7:0] alarm_bits, next_alarm_bits;
  logic awaiting_trigger_flag, next_awaiting_trigger_flag;
  logic log_wiped_flag, next_log_wiped_flag;
  logic next_logging_active_flag;
  logic [23:0] start_delay_minutes, next_start_delay_minutes;
  logic [23:0] delay_left, next_delay_left;
  logic [47:0] first_sample_timestamp, next_first_sample_timestamp;
  logic stamp_taken, next_stamp_taken;
  logic [23:0] mission_sample_count, next_mission_sample_count;
  logic [23:0] lifetime_sample_count, next_lifetime_sample_count;
  logic next_start_refused, next_sample_commit;
  logic [7:0] next_reg_rdata;
  logic mission_conv, forced_conv, t_alarm;
  logic [4:0] stamp_idx;

  // a conversion counts as a mission one only in the running phase
  always_comb begin
    mission_conv = conv_done && !conv_forced && phase == msc_pkg::MSC_RUN;
    forced_conv = conv_done && conv_forced;
    t_alarm = (t_hi && temp_high_en) || (t_lo && temp_low_en);
  end

  ////////////////////////////////////////////////////////////////////////////
  // mission sequencing, flags and counters
  always_comb begin
    next_phase = phase;
    next_alarm_bits = alarm_bits;
    next_awaiting_trigger_flag = awaiting_trigger_flag;
    next_log_wiped_flag = log_wiped_flag;
    next_logging_active_flag = logging_active_flag;
    next_start_delay_minutes = start_delay_minutes;
    next_delay_left = delay_left;
    next_first_sample_timestamp = first_sample_timestamp;
    next_stamp_taken = stamp_taken;
    next_mission_sample_count = mission_sample_count;
    next_lifetime_sample_count = lifetime_sample_count;
    next_start_refused = 1'b0;
    next_sample_commit = 1'b0;

    // host writes to the delay, one byte per address, blocked while logging
    if (reg_wr && !logging_active_flag) begin
      if (reg_addr == `MSC_DELAY_ADDR) next_start_delay_minutes[7:0] = reg_wdata;
      if (reg_addr == `MSC_DELAY_ADDR + 10'h001) next_start_delay_minutes[15:8] = reg_wdata;
      if (reg_addr == `MSC_DELAY_ADDR + 10'h002) next_start_delay_minutes[23:16] = reg_wdata;
    end

    // clear memory: wipe the mission record, awaiting flag untouched
    if (cmd_clear && !logging_active_flag) begin
      next_first_sample_timestamp = `MSC_STAMP_RESET;
      next_mission_sample_count = `MSC_COUNT_RESET;
      next_alarm_bits = 8'h00;
      next_log_wiped_flag = 1'b1;
      next_stamp_taken = 1'b0;
    end

    unique case (phase)
      msc_pkg::MSC_IDLE: begin
        if (cmd_start) begin
          if (!log_wiped_flag || (!log_temp_en && !log_humid_en)) begin
            next_start_refused = 1'b1;
          end else begin
            next_log_wiped_flag = 1'b0;
            next_logging_active_flag = 1'b1;
            next_awaiting_trigger_flag = start_on_trigger;
            next_delay_left = start_delay_minutes;
            next_phase = msc_pkg::MSC_DELAY;
          end
        end
        // forced conversion between missions feeds the battery gauge
        if (forced_conv) begin
          next_lifetime_sample_count = lifetime_sample_count + 24'h000001;
        end
      end
      msc_pkg::MSC_DELAY: begin
        // zero delay falls straight through; minutes counted on the rtc tick
        if (delay_left == 24'h000000) begin
          next_phase = start_on_trigger ? msc_pkg::MSC_WAIT_TRIG : msc_pkg::MSC_RUN;
        end else if (minute_tick) begin
          next_delay_left = delay_left - 24'h000001;
        end
      end
      msc_pkg::MSC_WAIT_TRIG: begin
        // each periodic check is a device sample; the trigger sample is not a mission one
        if (conv_done && !conv_forced) begin
          next_lifetime_sample_count = lifetime_sample_count + 24'h000001;
          if (t_alarm) begin
            next_awaiting_trigger_flag = 1'b0;
            next_sample_commit = 1'b1;
            next_phase = msc_pkg::MSC_RUN;
          end
        end
      end
      msc_pkg::MSC_RUN: begin
        if (mission_conv) begin
          // one increment per wake-up, however many readings it logs
          next_mission_sample_count = mission_sample_count + 24'h000001;
          next_lifetime_sample_count = lifetime_sample_count + 24'h000001;
          next_sample_commit = 1'b1;
        end
      end
      default: next_phase = msc_pkg::MSC_IDLE;
    endcase

    // first committed sample latches the rtc in the same cycle
    if (next_sample_commit && !stamp_taken) begin
      next_first_sample_timestamp = rtc_time;
      next_stamp_taken = 1'b1;
    end

    // alarm flags are sticky; trigger and mission and forced conversions all feed them
    if (mission_conv || forced_conv || (phase == msc_pkg::MSC_WAIT_TRIG && conv_done && !conv_forced)) begin
      if (t_hi && temp_high_en) next_alarm_bits[`MSC_TEMP_OVER_BIT] = 1'b1;
      if (t_lo && temp_low_en) next_alarm_bits[`MSC_TEMP_UNDER_BIT] = 1'b1;
      if (log_humid_en || forced_conv) begin
        if (h_hi && humid_high_en) next_alarm_bits[`MSC_HUMID_OVER_BIT] = 1'b1;
        if (h_lo && humid_low_en) next_alarm_bits[`MSC_HUMID_UNDER_BIT] = 1'b1;
      end
    end
    // a forced-conversion temperature alarm also releases a stale wait
    if (forced_conv && t_alarm && phase == msc_pkg::MSC_IDLE) begin
      next_awaiting_trigger_flag = 1'b0;
    end

    // stop or full memory ends the mission; awaiting flag stays as it is
    if ((cmd_stop || mission_end) && phase != msc_pkg::MSC_IDLE) begin
      next_logging_active_flag = 1'b0;
      next_phase = msc_pkg::MSC_IDLE;
    end

    // power loss wins over everything and is never gated
    if (power_on_event) begin
      next_alarm_bits[`MSC_POWER_LOSS_BIT] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    stamp_idx = 5'(reg_addr - `MSC_STAMP_ADDR);
    next_reg_rdata = 8'h00;
    unique case (reg_addr)
      `MSC_ALARM_ADDR: next_reg_rdata = alarm_bits | `MSC_ALARM_FIXED;
      `MSC_STATUS_ADDR: begin
        next_reg_rdata = `MSC_STATUS_FIXED;
        next_reg_rdata[`MSC_AWAIT_BIT] = awaiting_trigger_flag;
        next_reg_rdata[`MSC_WIPED_BIT] = log_wiped_flag;
        next_reg_rdata[`MSC_ACTIVE_BIT] = logging_active_flag;
      end
      `MSC_DELAY_ADDR: next_reg_rdata = start_delay_minutes[7:0];
      `MSC_DELAY_ADDR + 10'h001: next_reg_rdata = start_delay_minutes[15:8];
      `MSC_DELAY_ADDR + 10'h002: next_reg_rdata = start_delay_minutes[23:16];
      `MSC_MSAMP_ADDR: next_reg_rdata = mission_sample_count[7:0];
      `MSC_MSAMP_ADDR + 10'h001: next_reg_rdata = mission_sample_count[15:8];
      `MSC_MSAMP_ADDR + 10'h002: next_reg_rdata = mission_sample_count[23:16];
      `MSC_DSAMP_ADDR: next_reg_rdata = lifetime_sample_count[7:0];
      `MSC_DSAMP_ADDR + 10'h001: next_reg_rdata = lifetime_sample_count[15:8];
      `MSC_DSAMP_ADDR + 10'h002: next_reg_rdata = lifetime_sample_count[23:16];
      default: begin
        // timestamp bytes, lowest address holds seconds
        if (reg_addr >= `MSC_STAMP_ADDR && reg_addr <= `MSC_STAMP_LAST) begin
          next_reg_rdata = first_sample_timestamp[stamp_idx * 8 +: 8];
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      phase <= msc_pkg::MSC_IDLE;
      alarm_bits <= 8'h00;
      awaiting_trigger_flag <= 1'b0;
      log_wiped_flag <= 1'b0;
      logging_active_flag <= 1'b0;
      start_delay_minutes <= `MSC_DELAY_RESET;
      delay_left <= `MSC_DELAY_RESET;
      first_sample_timestamp <= `MSC_STAMP_RESET;
      stamp_taken <= 1'b0;
      mission_sample_count <= `MSC_COUNT_RESET;
      lifetime_sample_count <= `MSC_COUNT_RESET;
      start_refused <= 1'b0;
      sample_commit <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      phase <= next_phase;
      alarm_bits <= next_alarm_bits;
      awaiting_trigger_flag <= next_awaiting_trigger_flag;
      log_wiped_flag <= next_log_wiped_flag;
      logging_active_flag <= next_logging_active_flag;
      start_delay_minutes <= next_start_delay_minutes;
      delay_left <= next_delay_left;
      first_sample_timestamp <= next_first_sample_timestamp;
      stamp_taken <= next_stamp_taken;
      mission_sample_count <= next_mission_sample_count;
      lifetime_sample_count <= next_lifetime_sample_count;
      start_refused <= next_start_refused;
      sample_commit <= next_sample_commit;
      reg_rdata <= next_reg_rdata;
    end
  end
endmodule
`default_nettype wire

// ---- bench/msc_status_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "msc_cfg.svh"
module msc_status_asserts (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic conv_done,
  input wire logic log_temp_en,
  input wire logic log_humid_en,
  input wire logic mission_end,
  input wire logic start_refused,
  input wire logic sample_commit,
  input wire logic logging_active_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  // read path: fixed bits come back one cycle after the address
  a_alarm_fixed_bits: assert property (reg_addr == `MSC_ALARM_ADDR |=> reg_rdata[6:4] == 3'b111)
    else $error("alarm fixed bits wrong");
  a_status_fixed_bits: assert property (reg_addr == `MSC_STATUS_ADDR |=>
    reg_rdata[7:5] == 3'b110 && reg_rdata[2] == 1'b0 && reg_rdata[0] == 1'b0) else $error("status fixed bits wrong");
  // a start with no logging source can never succeed
  a_no_source_refused: assert property (cmd_start && !log_temp_en && !log_humid_en && !logging_active_flag
    |-> ##[1:2] start_refused) else $error("start without source not refused");
  a_refused_cause: assert property (start_refused |-> $past(cmd_start) || $past(cmd_start, 2))
    else $error("refusal without start");
  a_refused_quiet: assert property (start_refused |-> !$rose(logging_active_flag))
    else $error("refused start went active");
  a_active_rise_cause: assert property ($rose(logging_active_flag) |-> $past(cmd_start))
    else $error("mission active without start");
  a_active_fall_cause: assert property ($fell(logging_active_flag) |-> $past(cmd_stop) || $past(mission_end))
    else $error("mission ended without cause");
  a_stop_ends_mission: assert property (logging_active_flag && cmd_stop |=> !logging_active_flag)
    else $error("stop did not end mission");
  a_commit_cause: assert property (sample_commit |-> $past(conv_done) || $past(conv_done, 2))
    else $error("sample commit without conversion");
  c_refused: cover property (start_refused);
  c_started: cover property ($rose(logging_active_flag));
  c_committed: cover property (sample_commit);
endmodule
bind msc_mission_status msc_status_asserts i_msc_status_asserts (.sys_clk, .reset, .reg_addr, .reg_rdata,
  .cmd_start, .cmd_stop, .conv_done, .log_temp_en, .log_humid_en, .mission_end, .start_refused,
  .sample_commit, .logging_active_flag);
`default_nettype wire

// ---- bench/msc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module msc_host_model (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  output logic [9:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata
);
  ////////////////////////////////////////////////////////////////////////////////
  // host starts quiet; everything moves on the falling edge
  initial begin
    reg_addr = 10'h000;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  // write strobe lasts one cycle; data is inverted after so a stale byte never looks valid
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  // read data is registered, so it is taken one cycle after the address
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ---- bench/msc_mission_status_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "msc_cfg.svh"
module msc_mission_status_tb;
  localparam logic [6:0] P_PWR = 7'h40, P_START = 7'h20, P_STOP = 7'h10, P_CLR = 7'h08, P_MIN = 7'h04;
  localparam logic [6:0] P_CONV = 7'h02, P_END = 7'h01;
  logic sys_clk, reset, power_on_event, reg_wr, cmd_start, cmd_stop, cmd_clear, start_on_trigger;
  logic log_temp_en, log_humid_en, temp_high_en, temp_low_en, humid_high_en, humid_low_en, minute_tick;
  logic sample_tick, conv_done, conv_forced, mission_end, start_refused, sample_commit, logging_active_flag;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [15:0] temp_high_limit, temp_low_limit, humid_high_limit, humid_low_limit, temp_reading, humid_reading;
  logic [47:0] rtc_time;
  logic [6:0] ev;
  logic seen, cseen;
  logic [23:0] exp_dev;
  int n_fail, n_tests;
  assign {power_on_event, cmd_start, cmd_stop, cmd_clear, minute_tick, conv_done, mission_end} = ev;
  msc_mission_status i_msc_mission_status (.sys_clk, .reset, .power_on_event, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rdata, .cmd_start, .cmd_stop, .cmd_clear, .start_on_trigger, .log_temp_en, .log_humid_en, .temp_high_en,
    .temp_low_en, .humid_high_en, .humid_low_en, .temp_high_limit, .temp_low_limit, .humid_high_limit,
    .humid_low_limit, .minute_tick, .sample_tick, .conv_done, .conv_forced, .temp_reading, .humid_reading,
    .mission_end, .rtc_time, .start_refused, .sample_commit, .logging_active_flag);
  msc_host_model i_msc_host_model (.sys_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] e);
    n_tests++;
    if (got !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  // multi-byte registers are little endian, base address holds the low byte
  task automatic rdn(input logic [9:0] a, input int n, input logic [47:0] e);
    logic [7:0] b;
    logic [47:0] v;
    v = 48'h000000000000;
    for (int i = 0; i < n; i++) begin
      i_msc_host_model.rd(a + 10'(i), b);
      v[8*i +: 8] = b;
    end
    chk(v, e);
  endtask
  // one-cycle event pulse; a refusal may show one or two cycles later, so both are watched
  task automatic pulse(input logic [6:0] m);
    @(negedge sys_clk);
    ev = m;
    @(negedge sys_clk);
    ev = 7'h00;
    seen = start_refused;
    cseen = sample_commit;
    @(negedge sys_clk);
    seen = seen | start_refused;
  endtask
  task automatic conv(input logic [15:0] t, input logic [15:0] h, input logic f);
    temp_reading = t;
    humid_reading = h;
    conv_forced = f;
    pulse(P_CONV);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdn(`MSC_ALARM_ADDR, 1, 48'h70);
    rdn(`MSC_STATUS_ADDR, 1, 48'hc0);
    pulse(P_PWR);
    rdn(`MSC_ALARM_ADDR, 1, 48'hf0);
  endtask
  // temp low limit sits above the reading but is disabled, so only enabled flags may rise
  task automatic t_mission;
    pulse(P_CLR);
    rdn(`MSC_STATUS_ADDR, 1, 48'hc8);
    rdn(`MSC_ALARM_ADDR, 1, 48'h70);
    i_msc_host_model.wr(`MSC_DELAY_ADDR, 8'h02);
    rdn(`MSC_DELAY_ADDR, 3, 48'h2);
    pulse(P_START);
    chk({47'h0, seen}, 48'h0);
    rdn(`MSC_STATUS_ADDR, 1, 48'hc2);
    chk({47'h0, logging_active_flag}, 48'h1);
    i_msc_host_model.wr(`MSC_DELAY_ADDR, 8'h55);
    rdn(`MSC_DELAY_ADDR, 3, 48'h2);
    pulse(P_MIN);
    pulse(P_MIN);
    rtc_time = 48'h260315103045;
    conv(16'h000a, 16'h0010, 1'b0);
    exp_dev++;
    chk({47'h0, cseen}, 48'h1);
    rdn(`MSC_ALARM_ADDR, 1, 48'h76);
    rdn(`MSC_MSAMP_ADDR, 3, 48'h1);
    rdn(`MSC_DSAMP_ADDR, 3, {24'h0, exp_dev});
    rtc_time = 48'h260315103145;
    conv(16'h0030, 16'h0050, 1'b0);
    exp_dev++;
    rdn(`MSC_ALARM_ADDR, 1, 48'h7e);
    rdn(`MSC_STAMP_ADDR, 6, 48'h260315103045);
    rdn(`MSC_MSAMP_ADDR, 3, 48'h2);
    pulse(P_STOP);
    rdn(`MSC_STATUS_ADDR, 1, 48'hc0);
    pulse(P_START);
    chk({47'h0, seen}, 48'h1);
  endtask
  task automatic t_trigger;
    pulse(P_CLR);
    start_on_trigger = 1'b1;
    i_msc_host_model.wr(`MSC_DELAY_ADDR, 8'h01);
    pulse(P_START);
    rdn(`MSC_STATUS_ADDR, 1, 48'hd2);
    conv(16'h000b, 16'h0020, 1'b0);
    chk({47'h0, cseen}, 48'h0);
    rdn(`MSC_STATUS_ADDR, 1, 48'hd2);
    pulse(P_MIN);
    conv(16'h0008, 16'h0020, 1'b0);
    exp_dev++;
    rdn(`MSC_DSAMP_ADDR, 3, {24'h0, exp_dev});
    rdn(`MSC_STATUS_ADDR, 1, 48'hd2);
    conv(16'h000b, 16'h0020, 1'b0);
    exp_dev++;
    chk({47'h0, cseen}, 48'h1);
    rdn(`MSC_STATUS_ADDR, 1, 48'hc2);
    rdn(`MSC_ALARM_ADDR, 1, 48'h72);
    rdn(`MSC_MSAMP_ADDR, 3, 48'h0);
    rdn(`MSC_STAMP_ADDR, 6, 48'h260315103145);
    // full log raises mission_end, which ends the mission from the far side
    pulse(P_END);
    chk({47'h0, logging_active_flag}, 48'h0);
    rdn(`MSC_STATUS_ADDR, 1, 48'hc0);
  endtask
  // waiting flag survives stop and clear; the host then drops it with a -40 threshold
  task automatic t_await;
    pulse(P_CLR);
    pulse(P_START);
    pulse(P_STOP);
    rdn(`MSC_STATUS_ADDR, 1, 48'hd0);
    pulse(P_CLR);
    rdn(`MSC_STATUS_ADDR, 1, 48'hd8);
    temp_high_limit = 16'hffd8;
    conv(16'h0000, 16'h0020, 1'b1);
    exp_dev++;
    rdn(`MSC_STATUS_ADDR, 1, 48'hc8);
    rdn(`MSC_ALARM_ADDR, 1, 48'h72);
    rdn(`MSC_DSAMP_ADDR, 3, {24'h0, exp_dev});
    chk({47'h0, cseen}, 48'h0);
    // low alarm now enabled; reading under the low limit must raise temp_under_flag
    temp_low_en = 1'b1;
    conv(16'h0000, 16'h0020, 1'b1);
    exp_dev++;
    rdn(`MSC_ALARM_ADDR, 1, 48'h73);
    rdn(`MSC_DSAMP_ADDR, 3, {24'h0, exp_dev});
    log_temp_en = 1'b0;
    log_humid_en = 1'b0;
    pulse(P_START);
    chk({47'h0, seen}, 48'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset, ev, seen, sample_tick, conv_forced, start_on_trigger, temp_low_en} = 13'h1000;
    {log_temp_en, log_humid_en, temp_high_en, humid_high_en, humid_low_en} = 5'h1f;
    {temp_high_limit, temp_low_limit, humid_high_limit, humid_low_limit} = 64'h000a001400500010;
    {temp_reading, humid_reading, rtc_time} = 80'h0;
    n_fail = 0;
    n_tests = 0;
    exp_dev = 24'h000000;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    t_reset();
    t_mission();
    t_trigger();
    t_await();
    give_verdict();
  end
  // the whole sequence needs well under 1000 cycles
  initial begin
    #100us;
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
